// >>> verif/dpot_bus_master.sv
// behavioural two-wire bus master that makes clock, start and stop
`timescale 1ns/10ps
module dpot_bus_master (
  input wire logic i_clock,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // 1 means released; the pull-up makes it high. clock stands high between frames
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge i_clock);
  endtask : tick
  // data moves a cycle after the clock falls, never beside its edge
  task automatic start();
    tick(1);
    o_sda = 1'b1;
    tick(5);
    o_scl = 1'b1;
    tick(2);
    o_sda = 1'b0;
    tick(2);
    o_scl = 1'b0;
  endtask : start
  task automatic stop();
    tick(1);
    o_sda = 1'b0;
    tick(5);
    o_scl = 1'b1;
    tick(2);
    o_sda = 1'b1;
    tick(4);
  endtask : stop
  // low 300 ns, high 100 ns
  task automatic xfer_bit(input logic b, output logic r);
    tick(1);
    o_sda = b;
    tick(5);
    o_scl = 1'b1;
    tick(1);
    r = i_sda;
    tick(1);
    o_scl = 1'b0;
  endtask : xfer_bit
  task automatic xfer_byte(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
                           output logic ack_rx);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(tx[i], r);
      rx[i] = r;
    end
    xfer_bit(ack_tx, ack_rx);
  endtask : xfer_byte
endmodule : dpot_bus_master

// >>> verif/dpot_i2c_slave_props.sv
// pin-level assertions for the serial slave port
`timescale 1ns/10ps
module dpot_i2c_slave_props #(
  parameter int NV_CYCLES = 20
) (
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  input wire logic I_COMM_EN_N,
  input wire logic I_SCL,
  input wire logic I_SDA,
  input wire logic O_SDA,
  input wire logic O_SDA_OE,
  input wire logic O_VOLATILE,
  input wire logic O_NV_WRITE_START,
  input wire logic O_NV_BUSY
);
  // ************************************************************
  // helper logic
  // ************************************************************
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESETN);
  logic [31:0] busy_cnt_reg;
  logic [3:0] stop_age_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= I_SCL;
      sda_d_reg <= I_SDA;
    end
  end
  // saturates so a stale stop never looks recent
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      stop_age_reg <= 4'hF;
    end else if (I_SCL && scl_d_reg && I_SDA && !sda_d_reg) begin
      stop_age_reg <= 4'h0;
    end else if (stop_age_reg != 4'hF) begin
      stop_age_reg <= stop_age_reg + 4'h1;
    end
  end
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      busy_cnt_reg <= 32'h0;
    end else begin
      busy_cnt_reg <= O_NV_BUSY ? busy_cnt_reg + 32'h1 : 32'h0;
    end
  end
  // ************************************************************
  // assertions
  // ************************************************************
  AST_SDA_ZERO: assert property (O_SDA == 1'b0)
    else $error("data output value not low");
  AST_CE_QUIET: assert property (I_COMM_EN_N [*6] |=> !O_SDA_OE)
    else $error("data driven while disabled");
  AST_OE_SCL_LOW: assert property ($changed(O_SDA_OE) |-> !I_SCL && !$past(I_SCL, 2))
    else $error("data drive changed outside clock low");
  AST_START_PULSE: assert property (O_NV_WRITE_START |=> !O_NV_WRITE_START && O_NV_BUSY)
    else $error("storage start not a single pulse into busy");
  AST_BUSY_LEN: assert property ($fell(O_NV_BUSY) |-> busy_cnt_reg == NV_CYCLES)
    else $error("busy length wrong");
  AST_NV_VOLATILE_OFF: assert property (O_NV_WRITE_START |-> !O_VOLATILE)
    else $error("storage write in volatile mode");
  AST_NV_ON_STOP: assert property (O_NV_WRITE_START |-> stop_age_reg <= 4'h8)
    else $error("storage write without a recent stop");
  AST_NO_ACK_BUSY: assert property ($rose(O_SDA_OE) |-> !O_NV_BUSY)
    else $error("acknowledge while storage busy");
endmodule : dpot_i2c_slave_props
bind dpot_i2c_slave dpot_i2c_slave_props #(.NV_CYCLES(NV_CYCLES)) u_props (.I_CLOCK, .I_RESETN,
  .I_COMM_EN_N, .I_SCL, .I_SDA, .O_SDA, .O_SDA_OE, .O_VOLATILE, .O_NV_WRITE_START, .O_NV_BUSY);

// >>> verif/dpot_i2c_slave_tb.sv
// self-checking bench for the serial slave port
`timescale 1ns/10ps
module dpot_i2c_slave_tb;
  // long enough to poll once while busy
  localparam int NV = 400;
  logic clock;
  logic resetn_n;
  logic comm_en_n;
  logic [2:0] strap;
  logic apply_hold;
  logic scl;
  logic sda_m;
  logic sda_out;
  logic sda_oe;
  logic [5:0] wiper0;
  logic [5:0] wiper1;
  logic vol;
  logic zc;
  logic pos;
  logic nv_start;
  logic nv_busy;
  logic sda_wire;
  int failures = 0;
  int comparisons = 0;
  assign sda_wire = sda_oe ? 1'b0 : sda_m;
  always #25 clock = ~clock;
  dpot_i2c_slave #(.NV_CYCLES(NV)) dut (.I_CLOCK(clock), .I_RESETN(resetn_n),
    .I_COMM_EN_N(comm_en_n), .I_SCL(scl), .I_SDA(sda_wire), .O_SDA(sda_out), .O_SDA_OE(sda_oe),
    .I_ADDR_STRAP_BIT0(strap[0]), .I_ADDR_STRAP_BIT1(strap[1]), .I_ADDR_STRAP_BIT2(strap[2]),
    .I_APPLY_HOLD(apply_hold), .O_WIPER0(wiper0), .O_WIPER1(wiper1), .O_VOLATILE(vol),
    .O_ZC_EN(zc), .O_POS_CFG(pos), .O_NV_WRITE_START(nv_start), .O_NV_BUSY(nv_busy));
  dpot_bus_master m (.i_clock(clock), .i_sda(sda_wire), .o_scl(scl), .o_sda(sda_m));
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [7:0] adr(input logic [2:0] s, input logic rw);
    return {dpot_pkg::ADDR_FIXED, s, rw};
  endfunction : adr
  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic [7:0] rx;
    logic a;
    m.xfer_byte(b, 1'b1, rx, a);
    check("ack", {7'h0, a}, {7'h0, exp_ack});
  endtask : send
  task automatic recv(input logic [7:0] exp, input logic ack_tx);
    logic [7:0] rx;
    logic a;
    m.xfer_byte(8'hFF, ack_tx, rx, a);
    check("read", rx, exp);
  endtask : recv
  task automatic regs(input logic [5:0] w0, input logic [5:0] w1, input logic [2:0] cfg);
    check("wiper0", {2'h0, wiper0}, {2'h0, w0});
    check("wiper1", {2'h0, wiper1}, {2'h0, w1});
    check("config", {5'h0, vol, zc, pos}, {5'h0, cfg});
  endtask : regs
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (nv_busy !== lvl && n < 1000) begin
      m.tick(1);
      n++;
    end
    check("nv_busy", {7'h0, nv_busy}, {7'h0, lvl});
  endtask : wait_busy
  task automatic give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  // ************************************************************
  // tests
  // ************************************************************
  // the run needs about 4600 cycles; seven times that is a hang
  initial begin
    #1600000;
    failures++;
    give_verdict();
  end
  initial begin
    clock = 1'b0;
    resetn_n = 1'b0;
    comm_en_n = 1'b0;
    strap = 3'h5;
    apply_hold = 1'b0;
    repeat (6) @(posedge clock);
    @(negedge clock);
    resetn_n = 1'b1;
    m.tick(4);
    regs(6'h3F, 6'h3F, 3'h7);
    check("sda_value", {7'h0, sda_out}, 8'h00);
    for (int s = 0; s < 8; s++) begin
      strap = s[2:0];
      m.tick(4);
      m.start();
      send(adr(s[2:0], 1'b0), 1'b0);
      m.start();
      send(adr(s[2:0] + 3'h1, 1'b0), 1'b1);
      m.stop();
    end
    strap = 3'h5;
    m.tick(4);
    m.start();
    send(adr(3'h5, 1'b0), 1'b0);
    send(8'h05, 1'b0);
    send(8'h6A, 1'b0);
    send(8'hD1, 1'b0);
    send(8'h81, 1'b0);
    m.stop();
    regs(6'h05, 6'h2A, 3'h1);
    wait_busy(1'b1);
    m.start();
    send(adr(3'h5, 1'b0), 1'b1);
    m.stop();
    wait_busy(1'b0);
    m.start();
    send(adr(3'h5, 1'b1), 1'b0);
    recv(8'h05, 1'b0);
    recv(8'h2A, 1'b0);
    recv(8'h81, 1'b0);
    recv(8'h05, 1'b1);
    m.start();
    send(adr(3'h5, 1'b0), 1'b0);
    send(8'h07, 1'b0);
    m.stop();
    wait_busy(1'b1);
    wait_busy(1'b0);
    m.start();
    send(adr(3'h5, 1'b0), 1'b0);
    send(8'h87, 1'b0);
    send(8'h4C, 1'b0);
    m.stop();
    m.tick(40);
    check("nv_busy", {7'h0, nv_busy}, 8'h00);
    regs(6'h07, 6'h0C, 3'h7);
    m.start();
    send(adr(3'h4, 1'b0), 1'b1);
    send(8'h00, 1'b1);
    m.stop();
    comm_en_n = 1'b1;
    m.start();
    send(adr(3'h5, 1'b0), 1'b1);
    send(8'h00, 1'b1);
    m.stop();
    comm_en_n = 1'b0;
    m.tick(4);
    regs(6'h07, 6'h0C, 3'h7);
    // queue fills while application stalls, fifth byte refused
    apply_hold = 1'b1;
    m.start();
    send(adr(3'h5, 1'b0), 1'b0);
    send(8'h01, 1'b0);
    send(8'h42, 1'b0);
    send(8'h03, 1'b0);
    send(8'h44, 1'b0);
    send(8'h09, 1'b1);
    m.stop();
    regs(6'h07, 6'h0C, 3'h7);
    apply_hold = 1'b0;
    m.tick(20);
    regs(6'h03, 6'h04, 3'h7);
    // second reset while the bus idles; the configuration read with its top bit set shows the first bit out
    resetn_n = 1'b0;
    m.tick(3);
    resetn_n = 1'b1;
    m.tick(4);
    regs(6'h3F, 6'h3F, 3'h7);
    m.start();
    send(adr(3'h5, 1'b1), 1'b0);
    recv(8'h3F, 1'b0);
    recv(8'h3F, 1'b0);
    recv(8'h87, 1'b1);
    m.stop();
    give_verdict();
  end
endmodule : dpot_i2c_slave_tb

// >>> verilog/dpot_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
module dpot_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // refused at elaboration: the pointers wrap by plain overflow, so only powers of two work
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_params
    $error("dpot_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W:0] count_reg;
  logic push;
  logic pop;

  assign o_in_ready = (count_reg != DEPTH[PTR_W:0]);
  assign o_out_valid = (count_reg != '0);
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign o_out_data = mem[rd_ptr_reg];

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule : dpot_fifo

// >>> verilog/dpot_i2c_slave.sv
// two-wire serial slave port with wiper and configuration registers
`timescale 1ns/10ps

// Overview of operation
// - serial lines only heeded while enable is low
// - strap pins must equal received low address
// - address byte is 0101 then three straps
// - direction bit one means read
// - direction bit zero means write
// - matching address acknowledged by pulling low
// - byte after write address is command
// - read order: wiper0, wiper1, configuration
// - acknowledged configuration byte wraps to wiper0
// - stop after an accepted command byte in nonvolatile mode starts storage write
// - stop in volatile mode writes no storage
// - device never drives the clock
// - data falling with clock high is start
// - data rising with clock high is stop
// - repeated start handled like ordinary start
// - data changes only while clock low
// - incoming bits sampled on clock rise
// - idle until a start is seen
// - command top bits select target, reserved ignored
// - mismatched address ignored until next start
// - no address acknowledge while storage write busy
// - transmit bits change on falling clock edge
module dpot_i2c_slave #(
  parameter int NV_CYCLES = dpot_pkg::NV_WRITE_CYCLES,
  parameter int FIFO_WORDS = dpot_pkg::FIFO_DEPTH
) (
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  input wire logic I_COMM_EN_N,
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE,
  input wire logic I_ADDR_STRAP_BIT0,
  input wire logic I_ADDR_STRAP_BIT1,
  input wire logic I_ADDR_STRAP_BIT2,
  input wire logic I_APPLY_HOLD,
  output logic [dpot_pkg::WIPER_W-1:0] O_WIPER0,
  output logic [dpot_pkg::WIPER_W-1:0] O_WIPER1,
  output logic O_VOLATILE,
  output logic O_ZC_EN,
  output logic O_POS_CFG,
  output logic O_NV_WRITE_START,
  output logic O_NV_BUSY
);

  // refused at elaboration rather than at run time
  if (NV_CYCLES < 1 || FIFO_WORDS < 2) begin : g_bad_params
    $error("dpot_i2c_slave: NV_CYCLES must be >= 1 and FIFO_WORDS >= 2");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_DATA, ST_WR_ACK, ST_RD_DATA, ST_RD_ACK, ST_IGNORE
  } dpot_state_t;

  // ************************************************************
  // pin synchronisers and bus event detection
  // ************************************************************
  // pin order: enable_n, scl, sda, strap2, strap1, strap0
  logic [5:0] pins;
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic en_n;
  logic scl;
  logic sda;
  logic [2:0] strap;

  assign pins = {I_COMM_EN_N, I_SCL, I_SDA, I_ADDR_STRAP_BIT2, I_ADDR_STRAP_BIT1, I_ADDR_STRAP_BIT0};
  assign en_n = sync2_reg[5];
  assign scl = sync2_reg[4];
  assign sda = sync2_reg[3];
  assign strap = sync2_reg[2:0];

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sync1_reg <= 6'h3F;
      sync2_reg <= 6'h3F;
      scl_prev_reg <= 1'h1;
      sda_prev_reg <= 1'h1;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      scl_prev_reg <= scl;
      sda_prev_reg <= sda;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  assign scl_rise = !scl_prev_reg && scl;
  assign scl_fall = scl_prev_reg && !scl;
  // a data edge only counts while the clock is high on both samples
  assign start_ev = scl_prev_reg && scl && sda_prev_reg && !sda;
  assign stop_ev = scl_prev_reg && scl && !sda_prev_reg && sda;

  // ************************************************************
  // protocol state machine
  // ************************************************************
  dpot_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic [1:0] rd_sel_reg;
  logic drive_low_reg;
  logic rw_reg;
  logic ack_seen_reg;
  logic wrote_reg;
  logic nv_busy_reg;
  logic [31:0] nv_cnt_reg;
  logic fifo_in_ready;
  logic push_valid;
  dpot_pkg::dpot_cmd_t push_cmd;
  logic addr_match;
  logic [7:0] rd_byte;
  logic [1:0] rd_sel_next;
  logic nv_start;

  logic [dpot_pkg::WIPER_W-1:0] wiper0_reg;
  logic [dpot_pkg::WIPER_W-1:0] wiper1_reg;
  logic [dpot_pkg::CFG_W-1:0] cfg_reg;

  assign addr_match = (rx_reg[7:4] == dpot_pkg::ADDR_FIXED) && (rx_reg[3:1] == strap);

  // round robin read source; reserved code never selected
  assign rd_sel_next = (rd_sel_reg == dpot_pkg::SEL_CONFIG) ? dpot_pkg::SEL_WIPER0 : rd_sel_reg + 2'h1;

  always_comb begin
    rd_byte = {dpot_pkg::WIPER_READ_TOP, wiper0_reg};
    if (rd_sel_next == dpot_pkg::SEL_WIPER1) begin
      rd_byte = {dpot_pkg::WIPER_READ_TOP, wiper1_reg};
    end else if (rd_sel_next == dpot_pkg::SEL_CONFIG) begin
      rd_byte = {dpot_pkg::CFG_READ_TOP, cfg_reg};
    end
  end

  // command bytes are handed on only with a free fifo slot; a full fifo is answered by a not-acknowledge
  assign push_cmd.sel = rx_reg[dpot_pkg::SEL_MSB:dpot_pkg::SEL_LSB];
  assign push_cmd.value = rx_reg[dpot_pkg::WIPER_W-1:0];
  assign push_valid = (state_reg == ST_WR_DATA) && scl_fall && (bit_cnt_reg == 4'h8)
                      && (push_cmd.sel != dpot_pkg::SEL_RESERVED);

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      rd_sel_reg <= dpot_pkg::SEL_WIPER0;
      drive_low_reg <= 1'h0;
      rw_reg <= 1'h0;
      ack_seen_reg <= 1'h0;
    end else if (en_n) begin
      state_reg <= ST_IDLE;
      drive_low_reg <= 1'h0;
      bit_cnt_reg <= 4'h0;
    end else if (start_ev) begin
      state_reg <= ST_ADDR;
      drive_low_reg <= 1'h0;
      bit_cnt_reg <= 4'h0;
    end else if (stop_ev) begin
      state_reg <= ST_IDLE;
      drive_low_reg <= 1'h0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_WR_DATA: begin
          if (scl_rise && bit_cnt_reg != 4'h8) begin
            rx_reg <= {rx_reg[6:0], sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == ST_ADDR) begin
              rw_reg <= rx_reg[0];
              if (addr_match && !nv_busy_reg) begin
                state_reg <= ST_ADDR_ACK;
                drive_low_reg <= 1'h1;
              end else begin
                state_reg <= ST_IGNORE;
              end
            end else if (fifo_in_ready) begin
              state_reg <= ST_WR_ACK;
              drive_low_reg <= 1'h1;
            end else begin
              state_reg <= ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              state_reg <= ST_RD_DATA;
              rd_sel_reg <= dpot_pkg::SEL_WIPER0;
              tx_reg <= {dpot_pkg::WIPER_READ_TOP, wiper0_reg};
              // the first bit out is the fixed top bit of the wiper byte, never a wiper bit
              drive_low_reg <= ~dpot_pkg::WIPER_READ_TOP[1];
            end else begin
              state_reg <= ST_WR_DATA;
              drive_low_reg <= 1'h0;
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            state_reg <= ST_WR_DATA;
            drive_low_reg <= 1'h0;
          end
        end
        ST_RD_DATA: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_reg == 4'h8) begin
              state_reg <= ST_RD_ACK;
              drive_low_reg <= 1'h0;
            end else begin
              tx_reg <= {tx_reg[6:0], 1'h0};
              drive_low_reg <= ~tx_reg[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            ack_seen_reg <= ~sda;
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (ack_seen_reg) begin
              state_reg <= ST_RD_DATA;
              rd_sel_reg <= rd_sel_next;
              tx_reg <= rd_byte;
              drive_low_reg <= ~rd_byte[7];
            end else begin
              state_reg <= ST_IGNORE;
            end
          end
        end
        default: begin
          drive_low_reg <= 1'h0;
        end
      endcase
    end
  end

  // open drain: the line is only ever pulled low, never driven high
  assign O_SDA = 1'h0;
  assign O_SDA_OE = drive_low_reg;

  // ************************************************************
  // storage write on stop
  // ************************************************************
  // set wins over clear: a byte taken on the stop cycle is impossible, but a push still keeps the flag
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      wrote_reg <= 1'h0;
    end else if (push_valid && fifo_in_ready) begin
      wrote_reg <= 1'h1;
    end else if (stop_ev || start_ev || en_n) begin
      wrote_reg <= 1'h0;
    end
  end

  assign nv_start = stop_ev && !en_n && wrote_reg && !cfg_reg[dpot_pkg::CFG_VOLATILE_BIT];

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      nv_busy_reg <= 1'h0;
      nv_cnt_reg <= 32'h0;
    end else if (nv_start) begin
      nv_busy_reg <= 1'h1;
      nv_cnt_reg <= 32'(NV_CYCLES - 1);
    end else if (nv_busy_reg) begin
      if (nv_cnt_reg == 32'h0) begin
        nv_busy_reg <= 1'h0;
      end else begin
        nv_cnt_reg <= nv_cnt_reg - 32'h1;
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_NV_WRITE_START <= 1'h0;
    end else begin
      O_NV_WRITE_START <= nv_start;
    end
  end

  assign O_NV_BUSY = nv_busy_reg;

  // ************************************************************
  // command fifo and register file
  // ************************************************************
  logic fifo_out_valid;
  logic fifo_out_ready;
  dpot_pkg::dpot_cmd_t fifo_out_cmd;

  // updates wait while the analog side holds them off, and while storage is being written
  assign fifo_out_ready = !I_APPLY_HOLD && !nv_busy_reg;

  dpot_fifo #(
    .WIDTH(dpot_pkg::CMD_W),
    .DEPTH(FIFO_WORDS)
  ) u_cmd_fifo (
    .i_clock(I_CLOCK),
    .i_resetn(I_RESETN),
    .i_in_valid(push_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(push_cmd),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_out_cmd)
  );

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      wiper0_reg <= dpot_pkg::WIPER_RESET;
      wiper1_reg <= dpot_pkg::WIPER_RESET;
      cfg_reg <= dpot_pkg::CFG_RESET;
    end else if (fifo_out_valid && fifo_out_ready) begin
      if (fifo_out_cmd.sel == dpot_pkg::SEL_WIPER0) begin
        wiper0_reg <= fifo_out_cmd.value;
      end else if (fifo_out_cmd.sel == dpot_pkg::SEL_WIPER1) begin
        wiper1_reg <= fifo_out_cmd.value;
      end else if (fifo_out_cmd.sel == dpot_pkg::SEL_CONFIG) begin
        cfg_reg <= fifo_out_cmd.value[dpot_pkg::CFG_W-1:0];
      end
    end
  end

  assign O_WIPER0 = wiper0_reg;
  assign O_WIPER1 = wiper1_reg;
  assign O_VOLATILE = cfg_reg[dpot_pkg::CFG_VOLATILE_BIT];
  assign O_ZC_EN = cfg_reg[dpot_pkg::CFG_ZC_BIT];
  assign O_POS_CFG = cfg_reg[dpot_pkg::CFG_POS_BIT];

endmodule : dpot_i2c_slave

// >>> verilog/dpot_pkg.sv
// shared constants and types of the dual potentiometer serial slave port
package dpot_pkg;

  // ************************************************************
  // addressing and command coding
  // ************************************************************
  localparam logic [3:0] ADDR_FIXED = 4'h5;
  localparam int ADDR_STRAP_W = 3;
  localparam int BYTE_W = 8;
  localparam logic [1:0] SEL_WIPER0 = 2'h0;
  localparam logic [1:0] SEL_WIPER1 = 2'h1;
  localparam logic [1:0] SEL_CONFIG = 2'h2;
  localparam logic [1:0] SEL_RESERVED = 2'h3;
  localparam int SEL_MSB = 7;
  localparam int SEL_LSB = 6;

  // ************************************************************
  // register layout and reset values
  // ************************************************************
  localparam int WIPER_W = 6;
  localparam int CFG_W = 3;
  localparam int CFG_VOLATILE_BIT = 2;
  localparam int CFG_ZC_BIT = 1;
  localparam int CFG_POS_BIT = 0;
  localparam logic [CFG_W-1:0] CFG_RESET = 3'h7;
  // wiper reset is a plain default: the device starts in mute
  localparam logic [WIPER_W-1:0] WIPER_RESET = 6'h3F;
  localparam logic [1:0] WIPER_READ_TOP = 2'h0;
  localparam logic [4:0] CFG_READ_TOP = 5'h10;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ = 20000000;
  localparam int NV_WRITE_MS = 10;
  localparam int NV_WRITE_CYCLES = (CLK_HZ / 1000) * NV_WRITE_MS;
  localparam int FIFO_DEPTH = 4;

  // one received command byte on its way to the register file
  typedef struct packed {
    logic [1:0] sel;
    logic [WIPER_W-1:0] value;
  } dpot_cmd_t;

  localparam int CMD_W = $bits(dpot_cmd_t);

endpackage : dpot_pkg
